/* core/cpm_pkg.sv */
// Purpose: constants, types and carriers shared by the program-model register block
// Assumes: 10 MHz sys_clk_i, APB register access, 8-bit data path with 16-bit pointers
// Notes: offsets are byte addresses of aligned 32-bit words
//
// Behaviour
// - stack pointer addresses next free slot; reset value $00FF
// - stack low byte reload forces low byte $FF, upper byte kept
// - push decrements stack pointer, pull increments it
// - stack-relative operand address is stack pointer plus 8 or 16-bit offset
// - instruction pointer steps after each fetch; jumps and traps load a target
// - leaving reset, instruction pointer loads vector from $FFFE high, $FFFF low
// - condition flags eight bits; bits 6 and 5 always read one
// - overflow flag tracks two's complement overflow; signed branches use it
// - add and add-with-carry set nibble carry on carry from bit 3 to 4
// - decimal adjust correction comes from nibble carry and carry flags, from the low accumulator digit above 9 and from the accumulator above $99
// - mask blocks maskable interrupts; set after stacking, before vector fetch
// - interrupt entry never stacks upper index byte; software uses push/pull ops
// - when mask clears with several pending, highest priority served first
// - interrupt return restores stacked flags including mask
// - reset sets mask; only mask clear op and interrupt return may clear it
// - sign flag copies result bit 7 after data operations
// - zero flag set exactly when 8-bit result is $00
// - carry from bit 7 on add, borrow on subtract; shifts also update it
// - enabled break request finishes current instruction then runs soft trap
// - break vector $FFFC-$FFFD normally, $FEFC-$FEFD in monitor mode
// - interrupt return in break handler ends break if request deasserted
package cpm_pkg;

  localparam logic [7:0] OFF_STACK = 8'h00;
  localparam logic [7:0] OFF_IPTR = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [7:0] SP_LOW_RELOAD = 8'hff;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_BREAK = 16'hfffc;
  localparam logic [15:0] VEC_BREAK_MON = 16'hfefc;
  localparam logic [15:0] VEC_IRQ_TOP = 16'hfffa;

  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;
  localparam int FLG_V = 7;
  localparam logic [7:0] FLAGS_ONES = 8'h60;
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  localparam logic [7:0] BCD_LOW_FIX = 8'h06;
  localparam logic [7:0] BCD_HIGH_FIX = 8'h60;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_FETCH = 4'h1,
    OP_JUMP = 4'h2,
    OP_PUSH = 4'h3,
    OP_PULL = 4'h4,
    OP_RELOAD = 4'h5,
    OP_ALU = 4'h6,
    OP_MASK_CLR = 4'h7,
    OP_MASK_SET = 4'h8,
    OP_IRET = 4'h9
  } cpm_op_t;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_ADC = 3'h1,
    ALU_SUB = 3'h2,
    ALU_SBC = 3'h3,
    ALU_LOGIC = 3'h4,
    ALU_SHIFT = 3'h5,
    ALU_DAA = 3'h6
  } cpm_alu_t;

  typedef enum logic [1:0] {
    ST_VEC_HI = 2'b00,
    ST_VEC_LO = 2'b01,
    ST_RUN = 2'b10,
    ST_STACK = 2'b11
  } cpm_state_t;

  typedef struct packed {
    cpm_op_t op;
    cpm_alu_t alu;
    logic [7:0] a;
    logic [7:0] b;
    logic shift_c;
    logic [15:0] target;
    logic [7:0] pull_data;
    logic [15:0] offset;
    logic off_wide;
    logic insn_done;
  } cpm_seq_t;

endpackage

/* core/cpm_flags.sv */
// Purpose: result and flag generation for one committed data operation
// Assumes: purely combinational, fed from the sequencer in the same cycle
// Notes: bits 6 and 5 are forced high on the way out
`timescale 1ns/1ps
`default_nettype none
module cpm_flags (
  input wire cpm_pkg::cpm_alu_t kind_i, // operation kind
  input wire logic [7:0] a_i,           // accumulator operand
  input wire logic [7:0] b_i,           // second operand or finished result
  input wire logic shift_c_i,           // bit shifted out by a shift or rotate
  input wire logic [7:0] flags_i,       // current flags
  output logic [7:0] res_o,             // result byte
  output logic [7:0] flags_o            // updated flags
);
  logic [8:0] sum;
  logic [7:0] corr;
  logic sub;
  always_comb begin
    sum = 9'h000;
    corr = 8'h00;
    sub = (kind_i == cpm_pkg::ALU_SUB) || (kind_i == cpm_pkg::ALU_SBC);
    flags_o = flags_i;
    unique case (kind_i)
      cpm_pkg::ALU_ADD: sum = {1'b0, a_i} + {1'b0, b_i};
      cpm_pkg::ALU_ADC: sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, flags_i[cpm_pkg::FLG_C]};
      cpm_pkg::ALU_SUB: sum = {1'b0, a_i} - {1'b0, b_i};
      cpm_pkg::ALU_SBC: sum = {1'b0, a_i} - {1'b0, b_i} - {8'h00, flags_i[cpm_pkg::FLG_C]};
      cpm_pkg::ALU_DAA: begin
        if (flags_i[cpm_pkg::FLG_H] || (a_i[3:0] > 4'h9)) begin
          corr = corr | cpm_pkg::BCD_LOW_FIX;
        end
        if (flags_i[cpm_pkg::FLG_C] || (a_i > 8'h99)) begin
          corr = corr | cpm_pkg::BCD_HIGH_FIX;
        end
        sum = {1'b0, a_i} + {1'b0, corr};
      end
      default: sum = {1'b0, b_i};
    endcase
    res_o = sum[7:0];
    unique case (kind_i)
      cpm_pkg::ALU_ADD, cpm_pkg::ALU_ADC, cpm_pkg::ALU_SUB, cpm_pkg::ALU_SBC: begin
        flags_o[cpm_pkg::FLG_C] = sum[8];
        flags_o[cpm_pkg::FLG_V] = sub ? ((a_i[7] & ~b_i[7] & ~sum[7]) | (~a_i[7] & b_i[7] & sum[7])) :
                                        ((a_i[7] & b_i[7] & ~sum[7]) | (~a_i[7] & ~b_i[7] & sum[7]));
        if (!sub) begin
          flags_o[cpm_pkg::FLG_H] = (a_i[3] & b_i[3]) | (b_i[3] & ~sum[3]) | (~sum[3] & a_i[3]);
        end
      end
      cpm_pkg::ALU_LOGIC: flags_o[cpm_pkg::FLG_V] = 1'b0;
      cpm_pkg::ALU_SHIFT: begin
        flags_o[cpm_pkg::FLG_C] = shift_c_i;
        flags_o[cpm_pkg::FLG_V] = sum[7] ^ shift_c_i;
      end
      default: flags_o[cpm_pkg::FLG_C] = flags_i[cpm_pkg::FLG_C] | corr[6];
    endcase
    flags_o[cpm_pkg::FLG_N] = sum[7];
    flags_o[cpm_pkg::FLG_Z] = (sum[7:0] == 8'h00);
    flags_o = flags_o | cpm_pkg::FLAGS_ONES;
  end
endmodule
`default_nettype wire

/* core/cpm_prio.sv */
// Purpose: picks the highest-priority pending interrupt request
// Assumes: line 0 has the highest priority
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module cpm_prio (
  input wire logic [7:0] req_i, // pending requests
  output logic any_o,           // at least one pending
  output logic [2:0] idx_o      // winning line
);
  always_comb begin
    any_o = 1'b0;
    idx_o = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        idx_o = 3'(i);
      end
    end
  end
endmodule
`default_nettype wire

/* core/cpm_regs.sv */
// Purpose: programmer-visible pointers and condition flags with trap and vector sequencing
// Assumes: sequencer drives seq_i on sys_clk_i; memory answers vector reads on mem_valid_i
// Notes: APB slave with one wait state; core operations override APB writes in the same cycle
`timescale 1ns/1ps
`default_nettype none
module cpm_regs (
  input wire logic sys_clk_i,            // 10 MHz clock
  input wire logic rst_n_i,              // async reset, active low
  input wire logic psel_i,               // APB select
  input wire logic penable_i,            // APB enable
  input wire logic pwrite_i,             // APB direction
  input wire logic [7:0] paddr_i,        // APB byte address
  input wire logic [31:0] pwdata_i,      // APB write data
  output logic [31:0] prdata_o,          // APB read data
  output logic pready_o,                 // APB ready
  output logic pslverr_o,                // APB error on unmapped address
  input wire cpm_pkg::cpm_seq_t seq_i,   // sequencer command
  input wire logic stack_done_i,         // sequencer finished stacking registers
  input wire logic [7:0] mem_data_i,     // vector byte from memory
  input wire logic mem_valid_i,          // vector byte valid
  input wire logic brk_req_i,            // break request pin
  input wire logic monitor_i,            // monitor mode pin
  input wire logic [7:0] irq_req_i,      // maskable interrupt request pins
  output logic [15:0] stack_pointer_o,   // stack pointer
  output logic [15:0] instruction_pointer_o, // instruction pointer
  output logic [7:0] condition_flags_o,  // condition flags
  output logic [15:0] stack_ea_o,        // stack-relative operand address
  output logic [7:0] alu_res_o,          // committed data result
  output logic signed_lt_o,              // signed less-than condition
  output logic signed_le_o,              // signed less-or-equal condition
  output logic vec_req_o,                // vector byte read request
  output logic [15:0] vec_addr_o,        // vector byte address
  output logic stack_req_o,              // ask sequencer to stack registers
  output logic irq_take_o,               // maskable interrupt accepted, one cycle
  output logic [2:0] irq_idx_o,          // accepted interrupt line
  output logic running_o,                // executing instructions
  output logic brk_active_o              // break handler active
);

  typedef struct packed {
    logic [1:0] brk_sync;
    logic [1:0] mon_sync;
    logic [7:0] irq_s1;
    logic [7:0] irq_s2;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0] flags;
    cpm_pkg::cpm_state_t state;
    logic [15:0] vec_addr;
    logic [7:0] vec_hi;
    logic trap_brk;
    logic [2:0] trap_idx;
    logic brk_en;
    logic brk_active;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] ea;
    logic [7:0] alu_res;
    logic sgn_lt;
    logic sgn_le;
    logic vec_req;
    logic stack_req;
    logic irq_take;
    logic running;
  } cpm_st_t;

  cpm_st_t s;
  cpm_st_t next_s;
  logic [1:0] rst_q;
  logic rst_sync_n;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic irq_any;
  logic [2:0] irq_idx;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == cpm_pkg::OFF_STACK) || (a == cpm_pkg::OFF_IPTR) || (a == cpm_pkg::OFF_FLAGS) ||
                  (a == cpm_pkg::OFF_CTRL) || (a == cpm_pkg::OFF_STATUS);
  endfunction

  function automatic logic [15:0] irq_vector(input logic [2:0] idx);
    irq_vector = cpm_pkg::VEC_IRQ_TOP - {12'h000, idx, 1'b0};
  endfunction

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_q[1];

  cpm_flags u_flags (
    .kind_i(seq_i.alu),
    .a_i(seq_i.a),
    .b_i(seq_i.b),
    .shift_c_i(seq_i.shift_c),
    .flags_i(s.flags),
    .res_o(alu_res),
    .flags_o(alu_flags)
  );

  // masked lines never reach the arbiter
  cpm_prio u_prio (
    .req_i(s.irq_s2 & {8{~s.flags[cpm_pkg::FLG_I]}}),
    .any_o(irq_any),
    .idx_o(irq_idx)
  );

  always_comb begin
    next_s = s;
    next_s.brk_sync = {s.brk_sync[0], brk_req_i};
    next_s.mon_sync = {s.mon_sync[0], monitor_i};
    next_s.irq_s1 = irq_req_i;
    next_s.irq_s2 = s.irq_s1;
    next_s.irq_take = 1'b0;

    // APB: one wait state, answer registered
    if (psel_i && penable_i && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !addr_mapped(paddr_i);
      next_s.prdata = 32'h0000_0000;
      unique case (paddr_i)
        cpm_pkg::OFF_STACK: next_s.prdata = {16'h0000, s.sp};
        cpm_pkg::OFF_IPTR: next_s.prdata = {16'h0000, s.pc};
        cpm_pkg::OFF_FLAGS: next_s.prdata = {24'h00_0000, s.flags | cpm_pkg::FLAGS_ONES};
        cpm_pkg::OFF_CTRL: next_s.prdata = {31'h0000_0000, s.brk_en};
        cpm_pkg::OFF_STATUS: next_s.prdata = {24'h00_0000, s.trap_idx, s.state, s.vec_req,
                                              s.running, s.brk_active};
        default: next_s.prdata = 32'h0000_0000;
      endcase
    end else if (psel_i && penable_i && s.pready) begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      if (pwrite_i) begin
        unique case (paddr_i)
          cpm_pkg::OFF_STACK: next_s.sp = pwdata_i[15:0];
          cpm_pkg::OFF_IPTR: next_s.pc = pwdata_i[15:0];
          // a register write may set the mask but never clear it
          cpm_pkg::OFF_FLAGS: next_s.flags = pwdata_i[7:0] | cpm_pkg::FLAGS_ONES |
                                            (s.flags & (8'h01 << cpm_pkg::FLG_I));
          cpm_pkg::OFF_CTRL: next_s.brk_en = pwdata_i[0];
          default: next_s.brk_en = s.brk_en;
        endcase
      end
    end else begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
    end

    // stack-relative address follows the pointer every cycle
    next_s.ea = s.sp + (seq_i.off_wide ? seq_i.offset : {8'h00, seq_i.offset[7:0]});

    if (s.state == cpm_pkg::ST_RUN) begin
      unique case (seq_i.op)
        cpm_pkg::OP_NOP: next_s.pc = next_s.pc;
        cpm_pkg::OP_FETCH: next_s.pc = s.pc + 16'h0001;
        cpm_pkg::OP_JUMP: next_s.pc = seq_i.target;
        // also carries the upper index byte saved by handlers
        cpm_pkg::OP_PUSH: next_s.sp = s.sp - 16'h0001;
        cpm_pkg::OP_PULL: next_s.sp = s.sp + 16'h0001;
        cpm_pkg::OP_RELOAD: next_s.sp = {s.sp[15:8], cpm_pkg::SP_LOW_RELOAD};
        cpm_pkg::OP_ALU: begin
          next_s.flags = alu_flags;
          next_s.alu_res = alu_res;
        end
        cpm_pkg::OP_MASK_CLR: next_s.flags[cpm_pkg::FLG_I] = 1'b0;
        cpm_pkg::OP_MASK_SET: next_s.flags[cpm_pkg::FLG_I] = 1'b1;
        cpm_pkg::OP_IRET: begin
          next_s.sp = s.sp + 16'h0001;
          next_s.flags = seq_i.pull_data | cpm_pkg::FLAGS_ONES;
          if (s.brk_active && !s.brk_sync[1]) begin
            next_s.brk_active = 1'b0;
          end
        end
        default: next_s.pc = next_s.pc;
      endcase
    end

    unique case (s.state)
      cpm_pkg::ST_VEC_HI: begin
        if (mem_valid_i) begin
          next_s.vec_hi = mem_data_i;
          next_s.vec_addr = s.vec_addr + 16'h0001;
          next_s.state = cpm_pkg::ST_VEC_LO;
        end
      end
      cpm_pkg::ST_VEC_LO: begin
        if (mem_valid_i) begin
          next_s.pc = {s.vec_hi, mem_data_i};
          next_s.state = cpm_pkg::ST_RUN;
        end
      end
      cpm_pkg::ST_RUN: begin
        // traps only between instructions
        if (seq_i.insn_done && s.brk_en && s.brk_sync[1] && !s.brk_active) begin
          next_s.trap_brk = 1'b1;
          next_s.state = cpm_pkg::ST_STACK;
        end else if (seq_i.insn_done && irq_any && seq_i.op != cpm_pkg::OP_MASK_CLR) begin
          next_s.trap_brk = 1'b0;
          next_s.trap_idx = irq_idx;
          next_s.irq_take = 1'b1;
          next_s.state = cpm_pkg::ST_STACK;
        end
      end
      cpm_pkg::ST_STACK: begin
        if (stack_done_i) begin
          // mask goes up only once registers are saved, before the vector read
          next_s.flags[cpm_pkg::FLG_I] = 1'b1;
          if (s.trap_brk) begin
            next_s.brk_active = 1'b1;
            next_s.vec_addr = s.mon_sync[1] ? cpm_pkg::VEC_BREAK_MON : cpm_pkg::VEC_BREAK;
          end else begin
            next_s.vec_addr = irq_vector(s.trap_idx);
          end
          next_s.state = cpm_pkg::ST_VEC_HI;
        end
      end
    endcase

    next_s.flags = next_s.flags | cpm_pkg::FLAGS_ONES;
    next_s.vec_req = (next_s.state == cpm_pkg::ST_VEC_HI) || (next_s.state == cpm_pkg::ST_VEC_LO);
    next_s.stack_req = (next_s.state == cpm_pkg::ST_STACK);
    next_s.running = next_s.state == cpm_pkg::ST_RUN;
    next_s.sgn_lt = next_s.flags[cpm_pkg::FLG_N] ^ next_s.flags[cpm_pkg::FLG_V];
    next_s.sgn_le = next_s.flags[cpm_pkg::FLG_Z] | (next_s.flags[cpm_pkg::FLG_N] ^ next_s.flags[cpm_pkg::FLG_V]);
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s <= '0;
      s.sp <= cpm_pkg::SP_RESET;
      s.flags <= cpm_pkg::FLAGS_RESET;
      s.state <= cpm_pkg::ST_VEC_HI;
      s.vec_addr <= cpm_pkg::VEC_RESET;
      s.vec_req <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign stack_pointer_o = s.sp;
  assign instruction_pointer_o = s.pc;
  assign condition_flags_o = s.flags;
  assign stack_ea_o = s.ea;
  assign alu_res_o = s.alu_res;
  assign signed_lt_o = s.sgn_lt;
  assign signed_le_o = s.sgn_le;
  assign vec_req_o = s.vec_req;
  assign vec_addr_o = s.vec_addr;
  assign stack_req_o = s.stack_req;
  assign irq_take_o = s.irq_take;
  assign irq_idx_o = s.trap_idx;
  assign running_o = s.running;
  assign brk_active_o = s.brk_active;

endmodule
`default_nettype wire

/* test/cpm_regs_assertions.sv */
// Purpose: concurrent checks on pointers, flags and trap entry
// Assumes: bound to cpm_regs, one clock domain
// Notes: core-op checks are gated by running_o
`timescale 1ns/1ps
`default_nettype none
module cpm_regs_assertions (
  input wire logic sys_clk_i, // clock
  input wire logic rst_n_i, // reset pin
  input wire cpm_pkg::cpm_seq_t seq_i, // command
  input wire logic stack_done_i, // stacking done
  input wire logic [15:0] stack_pointer_o, // stack pointer
  input wire logic [15:0] instruction_pointer_o, // instr pointer
  input wire logic [7:0] condition_flags_o, // flags
  input wire logic [15:0] stack_ea_o, // operand address
  input wire logic [7:0] alu_res_o, // result
  input wire logic vec_req_o, // vector request
  input wire logic [15:0] vec_addr_o, // vector address
  input wire logic stack_req_o, // stacking request
  input wire logic irq_take_o, // irq accepted
  input wire logic running_o // executing
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic ovf;
  logic cy;
  logic hc;
  logic [15:0] off;
  logic [7:0] op;
  assign sum = {1'b0, seq_i.a} + {1'b0, seq_i.b};
  assign nib = {1'b0, seq_i.a[3:0]} + {1'b0, seq_i.b[3:0]};
  assign ovf = (seq_i.a[7] == seq_i.b[7]) && (sum[7] != seq_i.a[7]);
  assign cy = sum[8];
  assign hc = nib[4];
  assign off = seq_i.off_wide ? seq_i.offset : {8'h00, seq_i.offset[7:0]};
  assign op = {4'h0, seq_i.op} | {8{!running_o}};
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  reset_state_a: assert property (
    $rose(rst_n_i) |-> stack_pointer_o == 16'h00ff && condition_flags_o == 8'h68 && vec_addr_o == 16'hfffe)
    else $error("reset state wrong");
  ones_fixed_a: assert property (condition_flags_o[6:5] == 2'b11) else $error("flag bits 6 5 not one");
  sp_reload_a: assert property (
    op == 8'h05 |=> stack_pointer_o == {$past(stack_pointer_o[15:8]), 8'hff}) else $error("reload wrong");
  sp_push_a: assert property (
    op == 8'h03 |=> stack_pointer_o == $past(stack_pointer_o) - 16'h0001) else $error("push wrong");
  sp_pull_a: assert property (
    op == 8'h04 || op == 8'h09 |=> stack_pointer_o == $past(stack_pointer_o) + 16'h0001) else $error("pull wrong");
  ip_step_a: assert property (
    op == 8'h01 |=> instruction_pointer_o == $past(instruction_pointer_o) + 16'h0001) else $error("fetch wrong");
  ip_jump_a: assert property (
    op == 8'h02 |=> instruction_pointer_o == $past(seq_i.target)) else $error("jump wrong");
  stack_ea_a: assert property (
    running_o |=> stack_ea_o == $past(stack_pointer_o) + $past(off)) else $error("operand address wrong");
  add_flags_a: assert property (
    op == 8'h06 && seq_i.alu == cpm_pkg::ALU_ADD |=> condition_flags_o[0] == $past(cy)
    && condition_flags_o[4] == $past(hc) && condition_flags_o[7] == $past(ovf)) else $error("add flags wrong");
  sign_zero_a: assert property (
    op == 8'h06 |=> condition_flags_o[2] == alu_res_o[7] && condition_flags_o[1] == (alu_res_o == 8'h00))
    else $error("sign or zero wrong");
  irq_mask_a: assert property (irq_take_o |-> !$past(condition_flags_o[3])) else $error("irq while masked");
  mask_entry_a: assert property (
    stack_req_o && stack_done_i |=> condition_flags_o[3] && vec_req_o) else $error("mask not set on entry");
  mask_clear_a: assert property (
    $fell(condition_flags_o[3]) |-> $past(op) == 8'h07 || $past(op) == 8'h09) else $error("mask cleared");
endmodule
bind cpm_regs cpm_regs_assertions u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .seq_i(seq_i),
  .stack_done_i(stack_done_i), .stack_pointer_o(stack_pointer_o), .instruction_pointer_o(instruction_pointer_o),
  .condition_flags_o(condition_flags_o), .stack_ea_o(stack_ea_o), .alu_res_o(alu_res_o), .vec_req_o(vec_req_o),
  .vec_addr_o(vec_addr_o), .stack_req_o(stack_req_o), .irq_take_o(irq_take_o), .running_o(running_o));
`default_nettype wire

/* test/cpm_mem_model.sv */
// Purpose: memory and sequencer stand-in for vector reads and stacking
// Assumes: each answer comes after dly_i idle cycles
// Notes: byte at address a is a[15:8]^a[7:0]; data inverts once taken
`timescale 1ns/1ps
`default_nettype none
module cpm_mem_model (
  input wire logic sys_clk_i, // clock
  input wire logic rst_n_i, // reset, active low
  input wire logic [3:0] dly_i, // answer delay
  input wire logic vec_req_i, // byte wanted
  input wire logic [15:0] vec_addr_i, // byte address
  input wire logic stack_req_i, // stacking wanted
  output logic [7:0] mem_data_o, // vector byte
  output logic mem_valid_o, // byte valid
  output logic stack_done_o // stacking finished
);
  logic [3:0] cnt;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 4'h0;
      mem_valid_o <= 1'b0;
      stack_done_o <= 1'b0;
      mem_data_o <= 8'h00;
    end else begin
      mem_valid_o <= 1'b0;
      stack_done_o <= 1'b0;
      if (mem_valid_o) begin
        mem_data_o <= ~mem_data_o;
      end
      if ((vec_req_i || stack_req_i) && !mem_valid_o && !stack_done_o) begin
        cnt <= cnt + 4'h1;
        if (cnt >= dly_i) begin
          cnt <= 4'h0;
          mem_valid_o <= vec_req_i;
          stack_done_o <= !vec_req_i;
          mem_data_o <= vec_addr_i[15:8] ^ vec_addr_i[7:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* test/cpm_regs_test.sv */
// Purpose: self-checking bench for cpm_regs
// Assumes: APB slave answers after a wait state; vectors from cpm_mem_model
// Notes: ALU cases from a table, pointer, trap and reset cases by hand
`timescale 1ns/1ps
`default_nettype none
module cpm_regs_test;
  typedef struct packed {
    cpm_pkg::cpm_alu_t k;
    logic [7:0] a;
    logic [7:0] b;
    logic c;
    logic [7:0] res;
    logic [7:0] fl;
    logic [7:0] msk;
  } cpm_row_t;
  cpm_row_t rows [12] = '{
    '{cpm_pkg::ALU_ADD, 8'h7f, 8'h01, 1'b0, 8'h80, 8'h94, 8'h97},
    '{cpm_pkg::ALU_ADD, 8'hff, 8'h01, 1'b0, 8'h00, 8'h13, 8'h97},
    '{cpm_pkg::ALU_ADC, 8'h01, 8'h01, 1'b0, 8'h03, 8'h00, 8'h97},
    '{cpm_pkg::ALU_ADD, 8'h0f, 8'h01, 1'b0, 8'h10, 8'h10, 8'h97},
    '{cpm_pkg::ALU_SUB, 8'h00, 8'h01, 1'b0, 8'hff, 8'h05, 8'h87},
    '{cpm_pkg::ALU_SBC, 8'h05, 8'h01, 1'b0, 8'h03, 8'h00, 8'h87},
    '{cpm_pkg::ALU_SUB, 8'h80, 8'h01, 1'b0, 8'h7f, 8'h80, 8'h87},
    '{cpm_pkg::ALU_LOGIC, 8'h00, 8'h00, 1'b0, 8'h00, 8'h02, 8'h86},
    '{cpm_pkg::ALU_SHIFT, 8'h00, 8'h80, 1'b1, 8'h80, 8'h05, 8'h87},
    '{cpm_pkg::ALU_SHIFT, 8'h00, 8'h01, 1'b1, 8'h01, 8'h81, 8'h87},
    '{cpm_pkg::ALU_ADD, 8'h09, 8'h09, 1'b0, 8'h12, 8'h10, 8'h97},
    '{cpm_pkg::ALU_DAA, 8'h12, 8'h00, 1'b0, 8'h18, 8'h00, 8'h07}};
  logic clk = 1'b0;
  logic rst_n, psel, penable, pwrite, pready, pslverr, stack_done, mem_valid, brk_req, monitor;
  logic vreq, sreq, itake, run, bact, perr, slt, sle;
  logic [7:0] paddr, mem_data, irq_req, fl, res;
  logic [31:0] pwdata, prdata;
  logic [15:0] sp, ip, ea, vaddr;
  logic [2:0] iidx;
  logic [3:0] dly;
  cpm_pkg::cpm_seq_t seq;
  int n_mismatch = 0;
  int n_checks = 0;
  cpm_regs dut (.sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .seq_i(seq),
    .stack_done_i(stack_done), .mem_data_i(mem_data), .mem_valid_i(mem_valid), .brk_req_i(brk_req),
    .monitor_i(monitor), .irq_req_i(irq_req), .stack_pointer_o(sp), .instruction_pointer_o(ip),
    .condition_flags_o(fl), .stack_ea_o(ea), .alu_res_o(res), .signed_lt_o(slt), .signed_le_o(sle), .vec_req_o(vreq),
    .vec_addr_o(vaddr), .stack_req_o(sreq), .irq_take_o(itake), .irq_idx_o(iidx), .running_o(run),
    .brk_active_o(bact));
  cpm_mem_model mem (.sys_clk_i(clk), .rst_n_i(rst_n), .dly_i(dly), .vec_req_i(vreq), .vec_addr_i(vaddr),
    .stack_req_i(sreq), .mem_data_o(mem_data), .mem_valid_o(mem_valid), .stack_done_o(stack_done));
  always #50 clk = ~clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic op(input cpm_pkg::cpm_op_t o, input logic [15:0] v, input logic w, input logic d);
    @(posedge clk);
    seq <= {o, 20'h0, v, v[7:0], v, w, d};
    @(posedge clk);
    seq <= '0;
    @(negedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    @(negedge clk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(negedge clk);
    end
    perr = pslverr;
    chk(pready, 1'b1);
    @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_run();
    int k;
    k = 0;
    while (run !== 1'b1 && k < 200) begin
      k++;
      @(negedge clk);
    end
    chk(run, 1'b1);
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic pins(input logic b, input logic m, input logic [7:0] q);
    @(posedge clk);
    brk_req <= b;
    monitor <= m;
    irq_req <= q;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    logic [31:0] rd;
    logic [15:0] sp0;
    {rst_n, psel, penable, pwrite, brk_req, monitor} = 6'b00_0000;
    {paddr, irq_req, dly, pwdata} = '0;
    seq = '0;
    repeat (2) @(posedge clk);
    chk({sp, fl, vaddr}, 40'hff_68ff_fe);
    rst_n <= 1'b1;
    wait_run();
    chk(ip, 16'h0100);
    foreach (rows[i]) begin
      @(posedge clk);
      seq <= {cpm_pkg::OP_ALU, rows[i].k, rows[i].a, rows[i].b, rows[i].c, 42'h0};
      @(posedge clk);
      seq <= '0;
      @(negedge clk);
      chk(res, rows[i].res);
      chk(fl & rows[i].msk, rows[i].fl);
      chk({slt, sle}, {2{^(rows[i].fl & 8'h84)}} | rows[i].fl[1]);
    end
    op(cpm_pkg::OP_FETCH, 16'h0000, 1'b0, 1'b0);
    chk(ip, 16'h0101);
    op(cpm_pkg::OP_JUMP, 16'h1234, 1'b0, 1'b0);
    chk(ip, 16'h1234);
    apb(1'b1, cpm_pkg::OFF_STACK, 32'h0000_0180, rd);
    apb(1'b0, cpm_pkg::OFF_STACK, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0180);
    op(cpm_pkg::OP_PUSH, 16'h0000, 1'b0, 1'b0);
    chk(sp, 16'h017f);
    op(cpm_pkg::OP_PULL, 16'h0000, 1'b0, 1'b0);
    chk(sp, 16'h0180);
    op(cpm_pkg::OP_RELOAD, 16'h0000, 1'b0, 1'b0);
    chk(sp, 16'h01ff);
    op(cpm_pkg::OP_NOP, 16'hff81, 1'b0, 1'b0);
    chk(ea, 16'h0280);
    op(cpm_pkg::OP_NOP, 16'hff81, 1'b1, 1'b0);
    chk(ea, 16'h0180);
    apb(1'b1, cpm_pkg::OFF_FLAGS, 32'h0000_0000, rd);
    apb(1'b0, cpm_pkg::OFF_FLAGS, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0068);
    apb(1'b0, 8'h14, 32'h0000_0000, rd);
    chk({perr, rd}, 33'h1_0000_0000);
    pins(1'b0, 1'b0, 8'h28);
    op(cpm_pkg::OP_NOP, 16'h0000, 1'b0, 1'b1);
    chk(itake, 1'b0);
    op(cpm_pkg::OP_MASK_CLR, 16'h0000, 1'b0, 1'b0);
    chk(fl[3], 1'b0);
    sp0 = sp;
    op(cpm_pkg::OP_NOP, 16'h0000, 1'b0, 1'b1);
    chk({itake, iidx}, 4'hb);
    wait_run();
    chk({ip, fl[3], sp}, {17'h0_1615, sp0});
    pins(1'b0, 1'b0, 8'h00);
    op(cpm_pkg::OP_IRET, 16'h0000, 1'b0, 1'b0);
    chk({fl, sp}, {8'h60, sp0 + 16'h0001});
    apb(1'b1, cpm_pkg::OFF_CTRL, 32'h0000_0001, rd);
    pins(1'b1, 1'b0, 8'h00);
    op(cpm_pkg::OP_NOP, 16'h0000, 1'b0, 1'b1);
    wait_run();
    chk({bact, ip}, 17'h1_0302);
    pins(1'b0, 1'b0, 8'h00);
    op(cpm_pkg::OP_IRET, 16'h0000, 1'b0, 1'b0);
    chk(bact, 1'b0);
    dly <= 4'h4;
    pins(1'b1, 1'b1, 8'h00);
    op(cpm_pkg::OP_NOP, 16'h0000, 1'b0, 1'b1);
    wait_run();
    chk(ip, 16'h0203);
    op(cpm_pkg::OP_IRET, 16'h0000, 1'b0, 1'b0);
    chk(bact, 1'b1);
    pins(1'b0, 1'b0, 8'h00);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({sp, fl}, 24'h00ff_68);
    rst_n <= 1'b1;
    wait_run();
    chk(ip, 16'h0100);
    stop_test();
  end
  initial begin
    #(2_000_000);
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
